// ### dma_channel_irq.sv
// Summary of operation
// - Interrupt request stays low while any enabling condition holds.
// - Clearing the enable bit or writing FF to status drops request.
// - Request low on completion, block done, or line transition terms.
// - Continue mode sets block-done flag after first block ends.
// - Chaining modes set only completion, at the last block.
// - Line function chosen by line-function and device-type bits.
// - Function 00 status input, 01 status with interrupt, any type.
// - Start pulse barred for sync, ack-ready and native auto-request.
// - External abort barred for sync and ack-ready types.
// - Status mode sets line-transition flag on falling line.
// - Status-with-interrupt mode falling line raises request if enabled.
// - Start-pulse mode drives negative pulse after start processing.
// - Abort mode stops transfer, records abort code, sets error.
// - Start to pulse: 39, 59 or 61 clocks by chaining mode.
// - Bus error stops transfer, sets completion and error flags.
//
// Chosen here: the Wishbone register port and the register addresses.
`default_nettype none
module dma_channel_irq (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [dma_irq_pkg::ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [dma_irq_pkg::DAT_W-1:0] wb_dat_in,
  output logic [dma_irq_pkg::DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [dma_irq_pkg::NUM_CHAN-1:0] pcl_in,
  output logic [dma_irq_pkg::NUM_CHAN-1:0] pcl_out,
  output logic [dma_irq_pkg::NUM_CHAN-1:0] pcl_oe_out,
  input wire logic [dma_irq_pkg::NUM_CHAN-1:0] block_end_in,
  input wire logic [dma_irq_pkg::NUM_CHAN-1:0] last_block_in,
  input wire logic [dma_irq_pkg::NUM_CHAN-1:0] dev_done_in,
  input wire logic [dma_irq_pkg::NUM_CHAN-1:0] bus_error_in,
  output logic [dma_irq_pkg::NUM_CHAN-1:0] chan_active_out,
  output logic [dma_irq_pkg::NUM_CHAN-1:0] chan_stop_out,
  output logic int_req_n_out,
  output logic irq_out
);
  import dma_irq_pkg::*;

  // ********************************************************
  // Bus slave
  // ********************************************************
  logic bus_req, bus_wr, lane0;
  logic [NUM_CHAN-1:0] irq_cond, irq_stat_q, irq_mask_q;
  logic [NUM_CHAN-1:0] act_vec, stop_vec, pcl_o_vec, pcl_oe_vec;
  logic [DAT_W-1:0] chan_rd [NUM_CHAN];
  logic [DAT_W-1:0] rd_data;
  pcl_event_if pcl_ev ();

  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign bus_wr = bus_req && wb_we_in;
  assign lane0 = wb_sel_in[0];

  function automatic logic chan_hit(input logic [ADR_W-1:0] adr,
                                    input int ch, input logic [2:0] rg);
    chan_hit = !adr[7] && (adr[6:5] == 2'(ch)) && (adr[4:2] == rg)
               && (adr[1:0] == 2'b00);
  endfunction

  always_comb begin
    rd_data = '0;
    if (!wb_adr_in[7]) begin
      rd_data = chan_rd[wb_adr_in[6:5]];
    end else if (wb_adr_in == ADR_IRQ_STAT) begin
      rd_data = {{(DAT_W-NUM_CHAN){1'b0}}, irq_stat_q};
    end else if (wb_adr_in == ADR_IRQ_MASK) begin
      rd_data = {{(DAT_W-NUM_CHAN){1'b0}}, irq_mask_q};
    end
  end

  // Unmapped addresses still answer, reading zero
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_req && !wb_we_in) begin
        wb_dat_out <= rd_data;
      end
    end
  end

  // ********************************************************
  // Line synchroniser
  // ********************************************************
  pcl_sync u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pcl_in(pcl_in),
    .ev(pcl_ev.src)
  );

  // ********************************************************
  // Channels
  // ********************************************************
  genvar ch;
  for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    logic wr_ctrl, wr_stat, wr_devc, wr_opc;
    logic int_en_q, cont_q, str_q, request_gen_bits_h_q, pulse_q;
    logic [1:0] chain_q, device_type_bits_q;
    pcl_mode_type mode_q;
    logic [7:0] cer_q;
    logic coc_q, btc_q, ndt_q, err_q, pct_q;
    chan_state_type state_q;
    logic start_wr, timer_done, start_ok, abort_ok, busy;
    logic abort_ev, end_ev, stop_ev, pct_irq;
    logic [7:0] clr;

    assign wr_ctrl = bus_wr && lane0 && chan_hit(wb_adr_in, ch, REG_CTRL);
    assign wr_stat = bus_wr && lane0 && chan_hit(wb_adr_in, ch, REG_STAT);
    assign wr_devc = bus_wr && lane0 && chan_hit(wb_adr_in, ch, REG_DEVC);
    assign wr_opc = bus_wr && lane0 && chan_hit(wb_adr_in, ch, REG_OPC);
    assign clr = wr_stat ? wb_dat_in[7:0] : 8'h00;
    assign busy = (state_q != CH_IDLE);
    assign start_wr = wr_ctrl && wb_dat_in[CTRL_STR] && !busy;

    assign start_ok = (mode_q == PCL_START_PULSE) && (device_type_bits_q != DEVICE_TYPE_BITS_SYNC)
                      && (device_type_bits_q != DEVICE_TYPE_BITS_ACK_RDY)
                      && !((device_type_bits_q == DEVICE_TYPE_BITS_NATIVE) && !request_gen_bits_h_q);
    assign abort_ok = (mode_q == PCL_ABORT) && (device_type_bits_q != DEVICE_TYPE_BITS_SYNC)
                      && (device_type_bits_q != DEVICE_TYPE_BITS_ACK_RDY);
    assign abort_ev = abort_ok && pcl_ev.fall[ch] && busy;
    assign end_ev = (state_q == CH_ACTIVE) && block_end_in[ch]
                    && last_block_in[ch];
    assign stop_ev = abort_ev || bus_error_in[ch] && busy
                     || dev_done_in[ch] && busy;

    chan_start_timer u_timer (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .load_in(start_wr),
      .cancel_in(stop_ev),
      // Same write may carry the chain code, chain_q lags a cycle
      .chain_in(wb_dat_in[CTRL_CHAIN +: 2]),
      .done_out(timer_done)
    );

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        int_en_q <= 1'b0;
        cont_q <= 1'b0;
        chain_q <= CHAIN_NONE;
      end else if (wr_ctrl) begin
        int_en_q <= wb_dat_in[CTRL_INT];
        cont_q <= wb_dat_in[CTRL_CONT];
        if (!busy) begin
          chain_q <= wb_dat_in[CTRL_CHAIN +: 2];
        end
      end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        mode_q <= PCL_STATUS;
        device_type_bits_q <= DEVICE_TYPE_BITS_NATIVE;
        request_gen_bits_h_q <= 1'b0;
      end else begin
        if (wr_devc) begin
          mode_q <= pcl_mode_type'(wb_dat_in[DEVC_PCL +: 2]);
          device_type_bits_q <= wb_dat_in[DEVC_DEVICE_TYPE_BITS +: 2];
        end
        if (wr_opc) begin
          request_gen_bits_h_q <= wb_dat_in[OPC_REQUEST_GEN_BITS_H];
        end
      end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        state_q <= CH_IDLE;
        str_q <= 1'b0;
      end else begin
        case (state_q)
          CH_IDLE: begin
            if (start_wr) begin
              state_q <= CH_STARTING;
              str_q <= 1'b1;
            end
          end
          CH_STARTING: begin
            if (stop_ev) begin
              state_q <= CH_IDLE;
              str_q <= 1'b0;
            end else if (timer_done) begin
              state_q <= CH_ACTIVE;
              str_q <= 1'b0;
            end
          end
          CH_ACTIVE: begin
            if (stop_ev || end_ev) begin
              state_q <= CH_IDLE;
            end
          end
          default: begin
            state_q <= CH_IDLE;
            str_q <= 1'b0;
          end
        endcase
      end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        pulse_q <= 1'b0;
      end else begin
        pulse_q <= timer_done && start_ok && (state_q == CH_STARTING);
      end
    end
    assign pcl_o_vec[ch] = !pulse_q;
    assign pcl_oe_vec[ch] = start_ok;

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        cer_q <= CER_NONE;
      end else if (abort_ev) begin
        cer_q <= CER_EXT_ABORT;
      end else if (bus_error_in[ch] && busy) begin
        cer_q <= CER_BUS;
      end else if (start_wr) begin
        cer_q <= CER_NONE;
      end
    end

    // completion at last block, or on any stop: error, abort, device done
    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        coc_q <= 1'b0;
      end else begin
        coc_q <= end_ev || stop_ev || (coc_q && !clr[ST_COC]);
      end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        btc_q <= 1'b0;
      end else begin
        btc_q <= ((state_q == CH_ACTIVE) && block_end_in[ch]
                  && !last_block_in[ch] && cont_q
                  && (chain_q == CHAIN_NONE))
                 || (btc_q && !clr[ST_BTC]);
      end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        ndt_q <= 1'b0;
      end else begin
        ndt_q <= (dev_done_in[ch] && busy) || (ndt_q && !clr[ST_NDT]);
      end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        err_q <= 1'b0;
      end else begin
        err_q <= abort_ev || (bus_error_in[ch] && busy)
                 || (err_q && !clr[ST_ERR]);
      end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        pct_q <= 1'b0;
      end else begin
        pct_q <= (pcl_ev.fall[ch] && !mode_q[1])
                 || (pct_q && !clr[ST_PCT]);
      end
    end

    // request terms, line term only in interrupt mode
    assign pct_irq = pct_q && (mode_q == PCL_STATUS_IRQ);
    assign irq_cond[ch] = int_en_q && ((coc_q && !busy)
                          || (btc_q && busy && !coc_q && !ndt_q && !err_q)
                          || (pct_irq && !coc_q && !btc_q && !ndt_q
                              && !err_q));
    assign act_vec[ch] = busy;
    assign stop_vec[ch] = stop_ev;
    assign chan_rd[ch] =
      chan_hit(wb_adr_in, ch, REG_CTRL) ?
        {27'h0, cont_q, chain_q, str_q, int_en_q} :
      chan_hit(wb_adr_in, ch, REG_STAT) ?
        {24'h0, coc_q, btc_q, ndt_q, err_q, busy, 1'b0, pct_q,
         pcl_ev.level[ch]} :
      chan_hit(wb_adr_in, ch, REG_DEVC) ?
        {26'h0, device_type_bits_q, 2'b00, mode_q} :
      chan_hit(wb_adr_in, ch, REG_OPC) ? {30'h0, request_gen_bits_h_q, 1'b0} :
      chan_hit(wb_adr_in, ch, REG_ERR) ? {24'h0, cer_q} : '0;
  end

  // ********************************************************
  // Interrupt status, mask and outputs
  // ********************************************************
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask_q <= '0;
    end else if (bus_wr && lane0 && wb_adr_in == ADR_IRQ_MASK) begin
      irq_mask_q <= wb_dat_in[NUM_CHAN-1:0];
    end
  end

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_q <= '0;
    end else if (bus_wr && lane0 && wb_adr_in == ADR_IRQ_STAT) begin
      irq_stat_q <= irq_cond | (irq_stat_q & ~wb_dat_in[NUM_CHAN-1:0]);
    end else begin
      irq_stat_q <= irq_cond | irq_stat_q;
    end
  end

  // level request while any condition holds
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      int_req_n_out <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      int_req_n_out <= ~|irq_cond;
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pcl_out <= '1;
      pcl_oe_out <= '0;
      chan_active_out <= '0;
      chan_stop_out <= '0;
    end else begin
      pcl_out <= pcl_o_vec;
      pcl_oe_out <= pcl_oe_vec;
      chan_active_out <= act_vec;
      chan_stop_out <= stop_vec;
    end
  end
endmodule
`default_nettype wire

// ### dma_irq_pkg.sv
`default_nettype none
package dma_irq_pkg;
  localparam int NUM_CHAN = 4;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  // ********************************************************
  // Register map, word indices within a channel, byte addresses for shared registers
  // ********************************************************
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_DEVC = 3'h2;
  localparam logic [2:0] REG_OPC = 3'h3;
  localparam logic [2:0] REG_ERR = 3'h4;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h80;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h84;
  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int CTRL_INT = 0;
  localparam int CTRL_STR = 1;
  localparam int CTRL_CHAIN = 2;
  localparam int CTRL_CONT = 4;
  localparam int ST_COC = 7;
  localparam int ST_BTC = 6;
  localparam int ST_NDT = 5;
  localparam int ST_ERR = 4;
  localparam int ST_ACT = 3;
  localparam int ST_PCT = 1;
  localparam int ST_PCS = 0;
  localparam int DEVC_PCL = 0;
  localparam int DEVC_DEVICE_TYPE_BITS = 4;
  localparam int OPC_REQUEST_GEN_BITS_H = 1;
  // ********************************************************
  // Codes and timing
  // ********************************************************
  localparam logic [7:0] CER_NONE = 8'h00;
  localparam logic [7:0] CER_BUS = 8'h09;
  localparam logic [7:0] CER_EXT_ABORT = 8'h10;
  localparam logic [1:0] CHAIN_NONE = 2'h0;
  localparam logic [1:0] CHAIN_ARRAY = 2'h2;
  localparam logic [1:0] CHAIN_LINKED = 2'h3;
  localparam logic [1:0] DEVICE_TYPE_BITS_NATIVE = 2'h0;
  localparam logic [1:0] DEVICE_TYPE_BITS_SYNC = 2'h1;
  localparam logic [1:0] DEVICE_TYPE_BITS_ACK = 2'h2;
  localparam logic [1:0] DEVICE_TYPE_BITS_ACK_RDY = 2'h3;
  localparam logic [5:0] START_CLK_NONE = 6'd39;
  localparam logic [5:0] START_CLK_ARRAY = 6'd59;
  localparam logic [5:0] START_CLK_LINKED = 6'd61;
  typedef enum logic [1:0] {
    PCL_STATUS = 2'b00,
    PCL_STATUS_IRQ = 2'b01,
    PCL_START_PULSE = 2'b10,
    PCL_ABORT = 2'b11
  } pcl_mode_type;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_STARTING = 2'b01,
    CH_ACTIVE = 2'b10
  } chan_state_type;
endpackage
`default_nettype wire

// ### pcl_event_if.sv
`default_nettype none
interface pcl_event_if;
  import dma_irq_pkg::*;
  logic [NUM_CHAN-1:0] level;
  logic [NUM_CHAN-1:0] fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface
`default_nettype wire

// ### pcl_sync.sv
`default_nettype none
module pcl_sync (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [dma_irq_pkg::NUM_CHAN-1:0] pcl_in,
  pcl_event_if.src ev
);
  import dma_irq_pkg::*;
  genvar i;
  for (i = 0; i < NUM_CHAN; i++) begin : g_bit
    logic s1_q, s2_q, s3_q, stable_q, fall_q;
    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        s3_q <= 1'b1;
      end else begin
        s1_q <= pcl_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end
    // Level counts only once the last two stages agree
    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        stable_q <= 1'b1;
        fall_q <= 1'b0;
      end else begin
        fall_q <= stable_q && (s2_q == s3_q) && !s3_q;
        if (s2_q == s3_q) begin
          stable_q <= s3_q;
        end
      end
    end
    assign ev.level[i] = stable_q;
    assign ev.fall[i] = fall_q;
  end
endmodule
`default_nettype wire

// ### chan_start_timer.sv
`default_nettype none
module chan_start_timer (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic cancel_in,
  input wire logic [1:0] chain_in,
  output logic done_out
);
  import dma_irq_pkg::*;
  logic [5:0] count_q;
  logic run_q;

  function automatic logic [5:0] start_clocks(input logic [1:0] chain);
    case (chain)
      CHAIN_ARRAY: start_clocks = START_CLK_ARRAY;
      CHAIN_LINKED: start_clocks = START_CLK_LINKED;
      default: start_clocks = START_CLK_NONE;
    endcase
  endfunction

  // Counts from the write edge, pulse on the last count.
  // Chain code is read only at load, from the write data itself
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= 6'h00;
      run_q <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= run_q && (count_q == 6'h01);
      if (load_in) begin
        count_q <= start_clocks(chain_in) - 6'h01;
        run_q <= 1'b1;
      end else if (cancel_in || (run_q && count_q == 6'h01)) begin
        run_q <= 1'b0;
        count_q <= 6'h00;
      end else if (run_q) begin
        count_q <= count_q - 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### dma_irq_monitor.sv
`default_nettype none
module dma_irq_monitor (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic [3:0] pcl_out,
  input wire logic [3:0] pcl_oe_out,
  input wire logic [3:0] bus_error_in,
  input wire logic [3:0] chan_active_out,
  input wire logic [3:0] chan_stop_out
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence taken_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence ack_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  chk_ack_timing: assert property (taken_s |=> ack_s)
    else $error("ack missing or too long");
  chk_ack_cause: assert property ($rose(wb_ack_out) |->
    $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  chk_pulse_width: assert property (
    (pcl_out != 4'hF) |=> (pcl_out == 4'hF))
    else $error("start pulse not one cycle");
  chk_line_driven: assert property ((~pcl_out & ~pcl_oe_out) == 4'h0)
    else $error("line low while not driven");
  chk_pulse_after_start: assert property (
    (($past(pcl_out) & ~pcl_out) != 4'h0) |-> (($past(pcl_out) & ~pcl_out
    & ~(chan_active_out & $past(chan_active_out))) == 4'h0))
    else $error("start pulse before channel start");
  chk_error_stops: assert property (
    ((bus_error_in & chan_active_out) != 4'h0) |-> ##[1:2]
    (chan_stop_out != 4'h0))
    else $error("bus error did not stop transfer");
  chk_stop_idle: assert property ((chan_stop_out != 4'h0) |-> ##2
    ((chan_active_out & $past(chan_stop_out, 2)) == 4'h0))
    else $error("channel busy after stop");
  chk_stop_from_busy: assert property (
    (chan_stop_out & ~$past(chan_active_out)) == 4'h0)
    else $error("stop from idle channel");
endmodule
`default_nettype wire

// ### io_device_model.sv
`default_nettype none
module io_device_model (
  input wire logic clock_in,
  input wire logic [3:0] hold_low_in,
  input wire logic [3:0] pcl_out,
  input wire logic [3:0] pcl_oe_out,
  output logic [3:0] line_out
);
  // ****************************************
  // Open-drain control line
  // ****************************************
  logic [3:0] pull_q = 4'h0;
  always_ff @(posedge clock_in) begin
    pull_q <= hold_low_in;
  end
  // Pull-up wins once both sides let go
  assign line_out = ~pull_q & (~pcl_oe_out | pcl_out);
endmodule
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_irq_pkg::*;
  localparam logic [1:0] CHN [6] = '{CHAIN_NONE, CHAIN_ARRAY, CHAIN_LINKED,
    CHAIN_NONE, CHAIN_NONE, CHAIN_NONE};
  localparam logic [1:0] DTY [6] = '{DEVICE_TYPE_BITS_ACK, DEVICE_TYPE_BITS_NATIVE, DEVICE_TYPE_BITS_ACK,
    DEVICE_TYPE_BITS_SYNC, DEVICE_TYPE_BITS_ACK_RDY, DEVICE_TYPE_BITS_NATIVE};
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [DAT_W-1:0] wdat = 32'h0;
  logic [DAT_W-1:0] rdat;
  logic ack, int_req_n, irq;
  logic [NUM_CHAN-1:0] line, pcl_out, pcl_oe, active, stop;
  logic [NUM_CHAN-1:0] hold_low = 4'h0;
  logic [NUM_CHAN-1:0] blk_end = 4'h0;
  logic [NUM_CHAN-1:0] last_blk = 4'h0;
  logic [NUM_CHAN-1:0] dev_done = 4'h0;
  logic [NUM_CHAN-1:0] bus_err = 4'h0;
  logic [8:0] exp_q [$];
  logic [8:0] e;
  int num_errors = 0;
  int n_compared = 0;
  always #20 clock_in = ~clock_in;
  dma_channel_irq u_dut (.clock_in(clock_in), .rst_in(rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .pcl_in(line), .pcl_out(pcl_out), .pcl_oe_out(pcl_oe),
    .block_end_in(blk_end), .last_block_in(last_blk),
    .dev_done_in(dev_done), .bus_error_in(bus_err),
    .chan_active_out(active), .chan_stop_out(stop),
    .int_req_n_out(int_req_n), .irq_out(irq));
  io_device_model u_dev (.clock_in(clock_in), .hold_low_in(hold_low),
    .pcl_out(pcl_out), .pcl_oe_out(pcl_oe), .line_out(line));
  // ****************************************
  // Drivers and comparisons
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Upper data bits are random; only the low byte carries fields
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic c, input logic [7:0] x);
    logic [DAT_W-1:0] r;
    r = $urandom;
    r[7:0] = d;
    exp_q.push_back({c, x});
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= r;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clock_in);
    end while (ack !== 1'h1);
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'h1, a, d, 1'h0, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    acc(1'h0, a, 8'h00, 1'h1, x);
  endtask
  // Kind 0 block end, 1 device done, 2 bus error
  task automatic pulse(input int k, input int c);
    case (k)
      0: blk_end[c] <= 1'h1;
      1: dev_done[c] <= 1'h1;
      default: bus_err[c] <= 1'h1;
    endcase
    tick(1);
    blk_end <= 4'h0;
    dev_done <= 4'h0;
    bus_err <= 4'h0;
    tick(3);
  endtask
  task automatic line_low(input int c);
    hold_low[c] <= 1'h1;
    tick(10);
    hold_low[c] <= 1'h0;
    tick(10);
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock_in) begin
    if (ack === 1'h1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[8])
        cmp_val(rdat, {24'h0, e[7:0]});
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int ch, n;
    logic [7:0] b;
    logic [5:0] t;
    void'($urandom(65889));
    tick(10);
    rst_in <= 1'h0;
    tick(1);
    cmp_bit(int_req_n, 1'h1);
    rd(8'h10, CER_NONE);
    wr(8'h14, 8'h5A);
    rd(8'h14, 8'h00);
    ch = $urandom_range(3, 0);
    b = 8'(ch << 5);
    wr(b + 8'h08, 8'h00);
    wr(b, 8'h01);
    line_low(ch);
    cmp_bit(int_req_n, 1'h1);
    rd(b + 8'h04, 8'h03);
    wr(b + 8'h04, 8'hFF);
    rd(b + 8'h04, 8'h01);
    wr(b + 8'h08, 8'h01);
    line_low(ch);
    cmp_bit(int_req_n, 1'h0);
    cmp_bit(irq, 1'h0);
    wr(ADR_IRQ_MASK, 8'(1 << ch));
    tick(2);
    cmp_bit(irq, 1'h1);
    wr(b, 8'h00);
    tick(2);
    cmp_bit(int_req_n, 1'h1);
    wr(b, 8'h01);
    tick(2);
    cmp_bit(int_req_n, 1'h0);
    wr(b + 8'h04, 8'hFF);
    wr(ADR_IRQ_STAT, 8'hFF);
    tick(2);
    cmp_bit(int_req_n, 1'h1);
    cmp_bit(irq, 1'h0);
    for (int i = 0; i < 6; i++) begin
      ch = $urandom_range(3, 0);
      b = 8'(ch << 5);
      t = (CHN[i] == CHAIN_NONE) ? START_CLK_NONE :
          (CHN[i] == CHAIN_ARRAY) ? START_CLK_ARRAY : START_CLK_LINKED;
      wr(b + 8'h08, {2'h0, DTY[i], 4'h2});
      wr(b + 8'h0C, (i == 1) ? 8'h02 : 8'h00);
      wr(b, {4'h0, CHN[i], 2'h2});
      n = 1;
      while (pcl_out[ch] !== 1'h0 && n < 80) begin
        tick(1);
        n++;
      end
      cmp_val(32'(n), (i < 3) ? 32'(t) + 32'h1 : 32'h50);
      cmp_bit(pcl_oe[ch], i < 3);
      tick(3);
      pulse(0, ch);
      rd(b + 8'h04, 8'h09);
      last_blk[ch] <= 1'h1;
      pulse(0, ch);
      last_blk[ch] <= 1'h0;
      rd(b + 8'h04, 8'h81);
      wr(b + 8'h04, 8'hFF);
    end
    for (int j = 0; j < 2; j++) begin
      wr(b + 8'h08, {2'h0, (j == 0) ? DEVICE_TYPE_BITS_SYNC : DEVICE_TYPE_BITS_ACK, 4'h3});
      wr(b, 8'h02);
      tick(45);
      line_low(ch);
      rd(b + 8'h10, (j == 0) ? CER_NONE : CER_EXT_ABORT);
      rd(b + 8'h04, (j == 0) ? 8'h09 : 8'h91);
      if (j == 0)
        pulse(1, ch);
      wr(b + 8'h04, 8'hFF);
    end
    wr(b + 8'h08, 8'h00);
    wr(b, 8'h03);
    tick(45);
    pulse(2, ch);
    cmp_bit(int_req_n, 1'h0);
    rd(b + 8'h10, CER_BUS);
    rd(b + 8'h04, 8'h91);
    wr(b + 8'h04, 8'hFF);
    wr(b, 8'h13);
    tick(45);
    pulse(0, ch);
    cmp_bit(int_req_n, 1'h0);
    rd(b + 8'h04, 8'h49);
    wr(b + 8'h04, 8'hFF);
    tick(2);
    cmp_bit(int_req_n, 1'h1);
    test_done();
  end
  initial begin
    tick(20000);
    num_errors++;
    test_done();
  end
endmodule
bind dma_channel_irq dma_irq_monitor u_mon (.clock_in(clock_in),
  .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_ack_out(wb_ack_out), .pcl_out(pcl_out), .pcl_oe_out(pcl_oe_out),
  .bus_error_in(bus_error_in), .chan_active_out(chan_active_out),
  .chan_stop_out(chan_stop_out));
`default_nettype wire
